/* File: rtl/sba_pkg.sv */
package sba_pkg;

  // clock-state timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TSTATE_NS     = 250;
  localparam int unsigned TSTATE_CYCLES = (TSTATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [4:0] STATES_ADD_PRIMARY = 5'h0b;
  localparam logic [4:0] STATES_LONG        = 5'h0f;
  localparam logic [4:0] STATES_PAIR_STEP   = 5'h06;
  localparam logic [4:0] STATES_INDEX_STEP  = 5'h0a;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_REG_BASE = 8'h08;
  localparam logic [7:0] OFS_REG_LAST = 8'h1c;
  localparam logic [7:0] OFS_FLAGS    = 8'h20;

  // status fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_ILLEGAL_BIT = 1;
  localparam int unsigned ST_STATES_LSB  = 8;

  // prefixes and opcode patterns
  localparam logic [7:0] PFX_NONE    = 8'h00;
  localparam logic [7:0] PFX_EXT     = 8'hed;
  localparam logic [7:0] PFX_IDX_X   = 8'hdd;
  localparam logic [7:0] PFX_IDX_Y   = 8'hfd;
  localparam logic [1:0] GRP_00      = 2'h0;
  localparam logic [1:0] GRP_01      = 2'h1;
  localparam logic [3:0] OPC_ADD_LO  = 4'h9;
  localparam logic [3:0] OPC_INC_LO  = 4'h3;
  localparam logic [3:0] OPC_DEC_LO  = 4'hb;
  localparam logic [3:0] OPC_ADDC_LO = 4'ha;
  localparam logic [3:0] OPC_SUBB_LO = 4'h2;
  localparam logic [7:0] OPC_INC_IDX = 8'h23;
  localparam logic [7:0] OPC_DEC_IDX = 8'h2b;
  localparam logic [1:0] SEL_SELF    = 2'h2;

  // register file indices
  localparam logic [2:0] RI_FIRST   = 3'h0;
  localparam logic [2:0] RI_SECOND  = 3'h1;
  localparam logic [2:0] RI_PRIMARY = 3'h2;
  localparam logic [2:0] RI_STACK   = 3'h3;
  localparam logic [2:0] RI_INDEX_X = 3'h4;
  localparam logic [2:0] RI_INDEX_Y = 3'h5;

  // flag bit positions
  localparam int unsigned FB_CARRY    = 0;
  localparam int unsigned FB_SUBTRACT = 1;
  localparam int unsigned FB_OVERFLOW = 2;
  localparam int unsigned FB_NIBBLE   = 4;
  localparam int unsigned FB_NULL     = 6;
  localparam int unsigned FB_NEGATIVE = 7;

  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [15:0] ONE16     = 16'h0001;

  typedef enum logic [1:0] {
    SBA_ST_IDLE = 2'b01,
    SBA_ST_EXEC = 2'b10
  } sba_state_e;

  typedef enum logic [2:0] {
    SBA_FL_KEEP = 3'b001,
    SBA_FL_ADD  = 3'b010,
    SBA_FL_FULL = 3'b100
  } sba_flmode_e;

endpackage

/* File: rtl/sba_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sba_core_if;
  logic [15:0] operand_a;
  logic [15:0] operand_b;
  logic        carry_in;
  logic        subtract;
  logic [15:0] result;
  logic        half_flag;
  logic        carry_out;
  logic        overflow;
  logic        start;
  logic [4:0]  state_count;
  logic        done;

  modport alu (input operand_a, operand_b, carry_in, subtract,
               output result, half_flag, carry_out, overflow);
  modport timer (input start, state_count, output done);
  modport core (output operand_a, operand_b, carry_in, subtract, start, state_count,
                input result, half_flag, carry_out, overflow, done);
endinterface
`default_nettype wire

/* File: rtl/sba_adder16.sv */
`timescale 1ns/1ps
`default_nettype none
module sba_adder16
  import sba_pkg::*;
(
  sba_core_if.alu alu
);
  logic [16:0] wide;
  logic [12:0] low;

  always_comb
  begin
    if (alu.subtract)
    begin
      wide = {1'b0, alu.operand_a} - {1'b0, alu.operand_b} - {16'h0000, alu.carry_in};
      low  = {1'b0, alu.operand_a[11:0]} - {1'b0, alu.operand_b[11:0]}
             - {12'h000, alu.carry_in};
    end
    else
    begin
      wide = {1'b0, alu.operand_a} + {1'b0, alu.operand_b} + {16'h0000, alu.carry_in};
      low  = {1'b0, alu.operand_a[11:0]} + {1'b0, alu.operand_b[11:0]}
             + {12'h000, alu.carry_in};
    end
  end

  assign alu.result    = wide[15:0];
  assign alu.carry_out = wide[16];
  assign alu.half_flag = low[12];
  assign alu.overflow  = alu.subtract
                       ? (alu.operand_a[15] != alu.operand_b[15]) &&
                         (wide[15] != alu.operand_a[15])
                       : (alu.operand_a[15] == alu.operand_b[15]) &&
                         (wide[15] != alu.operand_a[15]);
endmodule // sba_adder16
`default_nettype wire

/* File: rtl/sba_tstate_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sba_tstate_timer
  import sba_pkg::*;
#(
  parameter int unsigned DIV = TSTATE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  sba_core_if.timer tmr
);
  // divider kept at 12 bits, so DIV may not pass 4096
  localparam logic [11:0] DIV_LAST = 12'(DIV - 1);

  typedef struct packed {
    logic [11:0] div_cnt;
    logic [4:0]  left;
    logic        running;
    logic        done;
  } sba_timer_s;

  sba_timer_s s;
  sba_timer_s next_s;

  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    if (tmr.start)
    begin
      next_s.running = 1'b1;
      next_s.left    = tmr.state_count;
      next_s.div_cnt = 12'h000;
    end
    else if (s.running)
    begin
      if (s.div_cnt == DIV_LAST)
      begin
        // one clock state elapsed
        next_s.div_cnt = 12'h000;
        if (s.left <= 5'h01)
        begin
          next_s.running = 1'b0;
          next_s.left    = 5'h00;
          next_s.done    = 1'b1;
        end
        else
        begin
          next_s.left = s.left - 5'h01;
        end
      end
      else
      begin
        next_s.div_cnt = s.div_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tmr.done = s.done;
endmodule // sba_tstate_timer
`default_nettype wire

/* File: rtl/sba_arith16.sv */
// Function
// - plain add of selected pair into primary
// - pair codes choose first, second, primary, stack
// - plain add updates nibble, subtract, carry only
// - extended add adds pair plus carry_in
// - add_with_carry sets all six flags
// - extended subtract removes pair and carry_in
// - subtract_with_borrow sets all flags, subtract set
// - index_x prefix add into index_x
// - index_x code 10 selects index_x itself
// - index_y prefix add into index_y
// - pair increment, six states, flags kept
// - index_x increment, ten states, flags kept
// - index_y increment, ten states, flags kept
// - pair decrement, six states, flags kept
// - index_x decrement, ten states, flags kept
// - index_y decrement, ten states, flags kept
`timescale 1ns/1ps
`default_nettype none
module sba_arith16
  import sba_pkg::*;
#(
  parameter int unsigned TSTATE_DIV = TSTATE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        busy
);

  typedef struct packed {
    sba_state_e      st;
    logic [5:0][15:0] regs;
    logic [7:0]      flags;
    sba_flmode_e     flmode;
    logic [2:0]      dest;
    logic [15:0]     op_a;
    logic [15:0]     op_b;
    logic            cin;
    logic            sub;
    logic            start;
    logic [4:0]      nstates;
    logic [15:0]     last_cmd;
    logic            illegal;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            busy;
  } sba_core_s;

  sba_core_s s;
  sba_core_s next_s;

  sba_core_if core_bus ();

  sba_adder16 u_adder (
    .alu (core_bus)
  );

  sba_tstate_timer #(
    .DIV (TSTATE_DIV)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (core_bus)
  );

  assign core_bus.operand_a   = s.op_a;
  assign core_bus.operand_b   = s.op_b;
  assign core_bus.carry_in    = s.cin;
  assign core_bus.subtract    = s.sub;
  assign core_bus.start       = s.start;
  assign core_bus.state_count = s.nstates;

  logic [7:0]  pfx;
  logic [7:0]  opc;
  logic [1:0]  sel;
  logic        d_ok;
  logic [2:0]  d_dest;
  logic [2:0]  d_src;
  logic        d_one;
  logic        d_sub;
  logic        d_cin;
  sba_flmode_e d_fl;
  logic [4:0]  d_states;
  logic [2:0]  idx;
  logic [7:0]  ofs;
  logic        upper_zero;
  logic        hit_cmd;
  logic        hit_status;
  logic        hit_flags;
  logic        hit_reg;
  logic [2:0]  ri;
  logic        setup;
  logic        access;
  logic        idle;

  // command decode straight from the write data
  always_comb
  begin
    pfx      = pwdata[15:8];
    opc      = pwdata[7:0];
    sel      = opc[5:4];
    d_ok     = 1'b0;
    d_dest   = RI_PRIMARY;
    d_src    = {1'b0, sel};
    d_one    = 1'b0;
    d_sub    = 1'b0;
    d_cin    = 1'b0;
    d_fl     = SBA_FL_KEEP;
    d_states = STATES_PAIR_STEP;
    idx      = (pfx == PFX_IDX_X) ? RI_INDEX_X : RI_INDEX_Y;
    case (pfx)
      PFX_NONE:
      begin
        if (opc[7:6] == GRP_00)
        begin
          case (opc[3:0])
            OPC_ADD_LO:
            begin
              d_ok     = 1'b1;
              d_fl     = SBA_FL_ADD;
              d_states = STATES_ADD_PRIMARY;
            end
            OPC_INC_LO:
            begin
              d_ok   = 1'b1;
              d_dest = {1'b0, sel};
              d_one  = 1'b1;
            end
            OPC_DEC_LO:
            begin
              d_ok   = 1'b1;
              d_dest = {1'b0, sel};
              d_one  = 1'b1;
              d_sub  = 1'b1;
            end
            default:
            begin
              d_ok = 1'b0;
            end
          endcase
        end
      end
      PFX_EXT:
      begin
        if (opc[7:6] == GRP_01)
        begin
          d_cin    = s.flags[FB_CARRY];
          d_fl     = SBA_FL_FULL;
          d_states = STATES_LONG;
          if (opc[3:0] == OPC_ADDC_LO)
          begin
            d_ok = 1'b1;
          end
          else if (opc[3:0] == OPC_SUBB_LO)
          begin
            d_ok  = 1'b1;
            d_sub = 1'b1;
          end
        end
      end
      PFX_IDX_X,
      PFX_IDX_Y:
      begin
        d_dest = idx;
        if (opc == OPC_INC_IDX)
        begin
          d_ok     = 1'b1;
          d_one    = 1'b1;
          d_states = STATES_INDEX_STEP;
        end
        else if (opc == OPC_DEC_IDX)
        begin
          d_ok     = 1'b1;
          d_one    = 1'b1;
          d_sub    = 1'b1;
          d_states = STATES_INDEX_STEP;
        end
        else if ((opc[7:6] == GRP_00) && (opc[3:0] == OPC_ADD_LO))
        begin
          d_ok     = 1'b1;
          d_src    = (sel == SEL_SELF) ? idx : {1'b0, sel};
          d_fl     = SBA_FL_ADD;
          d_states = STATES_LONG;
        end
      end
      default:
      begin
        d_ok = 1'b0;
      end
    endcase
  end

  // address decode
  always_comb
  begin
    ofs        = paddr[7:0];
    upper_zero = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    hit_cmd    = upper_zero && (ofs == OFS_CMD);
    hit_status = upper_zero && (ofs == OFS_STATUS);
    hit_flags  = upper_zero && (ofs == OFS_FLAGS);
    hit_reg    = upper_zero && (ofs >= OFS_REG_BASE) && (ofs <= OFS_REG_LAST);
    ri         = 3'(ofs[7:2] - OFS_REG_BASE[7:2]);
    setup      = psel && !penable;
    access     = psel && penable && s.pready;
    idle       = (s.st == SBA_ST_IDLE);
  end

  always_comb
  begin
    next_s       = s;
    next_s.start = 1'b0;

    // setup phase: answer prepared so the access phase completes at once
    if (setup)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !(hit_cmd || hit_status || hit_flags || hit_reg);
      // writes that would disturb a running command are refused
      if (pwrite && !idle && (hit_cmd || hit_flags || hit_reg))
      begin
        next_s.pslverr = 1'b1;
      end
      if (pwrite && hit_cmd && !d_ok)
      begin
        next_s.pslverr = 1'b1;
      end
      next_s.prdata = 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit_cmd)
        begin
          next_s.prdata = {16'h0000, s.last_cmd};
        end
        else if (hit_status)
        begin
          next_s.prdata[ST_BUSY_BIT]                    = s.busy;
          next_s.prdata[ST_ILLEGAL_BIT]                 = s.illegal;
          next_s.prdata[ST_STATES_LSB +: 5]             = s.nstates;
        end
        else if (hit_flags)
        begin
          next_s.prdata = {24'h000000, s.flags};
        end
        else if (hit_reg)
        begin
          next_s.prdata = {16'h0000, s.regs[ri]};
        end
      end
    end
    else if (access)
    begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite)
      begin
        if (hit_cmd && idle && !d_ok)
        begin
          next_s.illegal = 1'b1;
        end
        else if (hit_status && pwdata[ST_ILLEGAL_BIT])
        begin
          next_s.illegal = 1'b0;
        end
        if (!s.pslverr)
        begin
          if (hit_cmd)
          begin
            next_s.last_cmd = pwdata[15:0];
            next_s.op_a     = s.regs[d_dest];
            next_s.op_b     = d_one ? ONE16 : s.regs[d_src];
            next_s.cin      = d_cin;
            next_s.sub      = d_sub;
            next_s.dest     = d_dest;
            next_s.flmode   = d_fl;
            next_s.nstates  = d_states;
            next_s.start    = 1'b1;
            next_s.st       = SBA_ST_EXEC;
            next_s.busy     = 1'b1;
          end
          else if (hit_flags)
          begin
            next_s.flags = pwdata[7:0];
          end
          else if (hit_reg)
          begin
            next_s.regs[ri] = pwdata[15:0];
          end
        end
      end
    end

    // result is held back until the clock states have elapsed
    case (s.st)
      SBA_ST_IDLE:
      begin
      end
      SBA_ST_EXEC:
      begin
        if (core_bus.done)
        begin
          next_s.regs[s.dest] = core_bus.result;
          next_s.st           = SBA_ST_IDLE;
          next_s.busy         = 1'b0;
          case (s.flmode)
            SBA_FL_ADD:
            begin
              next_s.flags[FB_NIBBLE]   = core_bus.half_flag;
              next_s.flags[FB_SUBTRACT] = 1'b0;
              next_s.flags[FB_CARRY]    = core_bus.carry_out;
            end
            SBA_FL_FULL:
            begin
              next_s.flags[FB_NEGATIVE] = core_bus.result[15];
              next_s.flags[FB_NULL]     = (core_bus.result == 16'h0000);
              next_s.flags[FB_NIBBLE]   = core_bus.half_flag;
              next_s.flags[FB_OVERFLOW] = core_bus.overflow;
              next_s.flags[FB_SUBTRACT] = s.sub;
              next_s.flags[FB_CARRY]    = core_bus.carry_out;
            end
            default:
            begin
              // increments and decrements leave every flag alone
              next_s.flags = s.flags;
            end
          endcase
        end
      end
      default:
      begin
        next_s.st   = SBA_ST_IDLE;
        next_s.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s        <= '0;
      s.st     <= SBA_ST_IDLE;
      s.flmode <= SBA_FL_KEEP;
      s.flags  <= FLAGS_RST;
      s.regs   <= {6{REG_RST}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign busy    = s.busy;

endmodule // sba_arith16
`default_nettype wire

/* File: testbench/sba_arith16_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sba_arith16_chk
  import sba_pkg::*;
#(
  parameter int unsigned TSTATE_DIV = TSTATE_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy
);
  // longest command is fifteen states plus two cycles of launch and retire
  localparam int T_MAX = 2 + 15 * TSTATE_DIV;
  logic cmd;
  assign cmd = psel && penable && pready && pwrite && paddr == 12'h000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_misaligned_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_cmd_start: assert property (cmd && !pslverr |=> busy)
    else $error("accepted command did not start");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:T_MAX] !busy)
    else $error("command ran too long");
  a_busy_min: assert property ($rose(busy) |-> busy[*8])
    else $error("command ended too early");
  a_busy_refuse: assert property ((psel && !penable && pwrite && paddr == 12'h000 && busy)
    ##1 busy |-> pslverr)
    else $error("command accepted while busy");
  a_ext_refuse: assert property (psel && !penable && pwrite && !busy
    && paddr == 12'h000 && pwdata[15:8] == 8'hed && pwdata[7:6] == 2'h1
    && pwdata[3:0] != 4'ha && pwdata[3:0] != 4'h2 |=> pslverr)
    else $error("unsupported extended opcode accepted");
  a_idle_stay: assert property (!busy && !cmd |=> !busy)
    else $error("busy without command");
  a_reg_width: assert property (pready && !pwrite && !pslverr && paddr >= 12'h008
    && paddr <= 12'h01c |-> prdata[31:16] == 16'h0000)
    else $error("register wider than sixteen bits");

  cover property (cmd && !pslverr);
  cover property ($fell(busy));
  cover property (pslverr && pwrite);
endmodule // sba_arith16_chk

bind sba_arith16 sba_arith16_chk #(.TSTATE_DIV(TSTATE_DIV)) sba_arith16_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));
`default_nettype wire

/* File: testbench/tb_sixteen_bit_arithmetic.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sixteen_bit_arithmetic;
  import sba_pkg::*;
  // short state so the whole opcode table runs in a few thousand cycles
  localparam int DIV = 1;
  localparam logic [15:0] OPS [11] = '{16'h0009, 16'hed4a, 16'hed42, 16'hdd09, 16'hfd09,
    16'h0003, 16'h000b, 16'hdd23, 16'hfd23, 16'hdd2b, 16'hfd2b};
  localparam int DST [11] = '{2, 2, 2, 4, 5, -1, -1, 4, 5, 4, 5};
  localparam int KND [11] = '{0, 1, 2, 0, 0, 3, 4, 3, 3, 4, 4};
  localparam int NST [11] = '{11, 15, 15, 15, 15, 6, 6, 10, 10, 10, 10};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic [31:0] q;
  logic        e;
  logic [15:0] r [6];
  logic [7:0]  fl;
  int          fails = 0;
  int          samples_checked = 0;

  sba_arith16 #(.TSTATE_DIV(DIV)) sba_arith16_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

  always #4 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a missing ready is caught by the watchdog
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle(output int w);
    w = 0;
    do
    begin
      @(negedge pclk);
      if (busy === 1'b1)
        w++;
    end
    while (busy === 1'b1 && w < 1000);
  endtask

  task automatic run(input logic [15:0] cmd, input int d, input int s, input int k,
                     input int n);
    logic [16:0] x;
    logic [12:0] h;
    logic [15:0] a;
    logic [15:0] b;
    logic        ci;
    logic        v;
    int          w;
    for (int i = 0; i < 6; i++)
      xfer(1'b1, 12'(8 + 4 * i), {16'h0, r[i]});
    xfer(1'b1, 12'h020, {24'h0, fl});
    xfer(1'b1, 12'h000, {16'h0, cmd});
    chk({31'h0, e}, 32'h0);
    wait_idle(w);
    chk(w, 2 + n * DIV);
    a = r[d];
    b = (k == 3) ? 16'h0001 : (k == 4) ? 16'hffff : r[s];
    ci = (k == 1 || k == 2) ? fl[0] : 1'b0;
    if (k == 2)
    begin
      x = {1'b0, a} - b - ci;
      h = {1'b0, a[11:0]} - b[11:0] - ci;
      v = (a[15] != b[15]) && (x[15] != a[15]);
    end
    else
    begin
      x = a + b + ci;
      h = a[11:0] + b[11:0] + ci;
      v = (a[15] == b[15]) && (x[15] != a[15]);
    end
    if (k == 0)
      fl = {fl[7:6], 1'b0, h[12], 1'b0, fl[2], 1'b0, x[16]};
    else if (k < 3)
      fl = {x[15], x[15:0] == 16'h0, 1'b0, h[12], 1'b0, v, k == 2, x[16]};
    r[d] = x[15:0];
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, 12'(8 + 4 * i), 32'h0);
      chk(q, {16'h0, r[i]});
    end
    xfer(1'b0, 12'h020, 32'h0);
    chk(q, {24'h0, fl});
    xfer(1'b0, 12'h004, 32'h0);
    chk({19'h0, q[12:0]}, {19'h0, 5'(n), 8'h00});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // about 35 commands of under 100 cycles each; over ten times that is ample
  initial
  begin
    #400000;
    fails++;
    finish_test();
  end

  initial
  begin
    int k;
    int w;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b0, 12'(4 * i), 32'h0);
      chk(q, 32'h0);
    end
    $display("test reset done");
    xfer(1'b0, 12'h024, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h102, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h000, 32'h0000ed44);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 12'h004, 32'h0);
    chk({30'h0, q[1:0]}, 32'h2);
    xfer(1'b1, 12'h004, 32'h2);
    xfer(1'b0, 12'h004, 32'h0);
    chk({30'h0, q[1:0]}, 32'h0);
    $display("test refuse done");
    for (int t = 0; t < 11; t++)
      for (int g = 0; g < 4; g++)
        if (t < 7 || g == 0)
        begin
          k = t * 4 + g;
          for (int i = 0; i < 6; i++)
            r[i] = ((t + g) % 2 == 1) ? 16'(i - 1) : 16'(32'h1fff * (k + i + 1));
          // index steps run on set flags so a flag clear would show
          fl = (k % 3 == 0 || t > 6) ? 8'hd7 : 8'h00;
          run(OPS[t] | 16'(t < 7 ? g << 4 : 0), DST[t] < 0 ? g : DST[t],
              g == 2 ? (DST[t] < 0 ? g : DST[t]) : g, KND[t], NST[t]);
        end
    $display("test opcodes done");
    xfer(1'b1, 12'h000, 32'h00000023);
    xfer(1'b1, 12'h000, 32'h0000000b);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h010, 32'h00001234);
    chk({31'h0, e}, 32'h1);
    wait_idle(w);
    xfer(1'b0, 12'h010, 32'h0);
    chk(q, {16'h0, r[2] + 16'h0001});
    $display("test busy done");
    finish_test();
  end
endmodule // tb_sixteen_bit_arithmetic
`default_nettype wire
